/* File: rtl/pfs_pin_mux.sv */
// pin function select and routing for port E pins 8 to 11
//
// Notes on behaviour
// - pin 10: 000 port, 001 timer C
// - reserved bits always read as zero
// - pin 9: 000 port, 001 timer B
// - pin 8 field bits 2:0, RW, reset 0
// - pin 8: 000 port, 001 timer A
// - pin 9 and 10 fields RW, reset 0
// - pin 11: 000 port, 001 timer D
`include "pfs_defines.svh"

module pfs_pin_mux #(
    parameter int NUM_PINS = `PFS_NUM_PINS
) (
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire pfs_pkg::pfs_addr_t regAddr,
    input wire pfs_pkg::pfs_data_t regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output pfs_pkg::pfs_data_t regRdData,
    // pins, index 0 is pin 8
    input wire logic [NUM_PINS-1:0] pinIn,
    output logic [NUM_PINS-1:0] pinOut,
    output logic [NUM_PINS-1:0] pinOe,
    // port logic side
    input wire logic [NUM_PINS-1:0] portOut,
    input wire logic [NUM_PINS-1:0] portOe,
    output logic [NUM_PINS-1:0] portIn,
    // timer channel 3 side, index 0 is channel A
    input wire logic [NUM_PINS-1:0] timerOut,
    input wire logic [NUM_PINS-1:0] timerOe,
    output logic [NUM_PINS-1:0] timerIn
);
    import pfs_pkg::*;

    // ==========================================================
    // elaboration check
    if (NUM_PINS != `PFS_NUM_PINS) begin : g_bad_pins
        $error("pfs_pin_mux serves exactly four pins");
    end

    // ==========================================================
    // function register
    pfs_data_t funcReg;
    pfs_data_t funcNext;
    pfs_data_t rdDataReg;
    pfs_data_t rdDataNext;
    logic hitFunc;

    assign hitFunc = (regAddr == `PFS_OFS_FUNC);

    always_comb begin
        funcNext = funcReg;
        rdDataNext = `PFS_READ_IDLE;
        if (regWrEn && hitFunc) begin
            // reserved bits are never stored
            funcNext = regWrData & ~`PFS_RSV_MASK;
        end
        if (regRdEn && hitFunc) begin
            rdDataNext = funcReg & ~`PFS_RSV_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            funcReg <= `PFS_RST_VAL;
            rdDataReg <= `PFS_READ_IDLE;
        end else begin
            funcReg <= funcNext;
            rdDataReg <= rdDataNext;
        end
    end

    assign regRdData = rdDataReg;

    // ==========================================================
    // per-pin routing
    pfs_field_t pinMode [NUM_PINS];
    logic [NUM_PINS-1:0] syncA;
    logic [NUM_PINS-1:0] syncB;
    logic [NUM_PINS-1:0] pinOutReg;
    logic [NUM_PINS-1:0] pinOutNext;
    logic [NUM_PINS-1:0] pinOeReg;
    logic [NUM_PINS-1:0] pinOeNext;
    logic [NUM_PINS-1:0] portInReg;
    logic [NUM_PINS-1:0] portInNext;
    logic [NUM_PINS-1:0] timerInReg;
    logic [NUM_PINS-1:0] timerInNext;

    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        assign pinMode[i] =
            funcReg[i*`PFS_FIELD_STRIDE +: `PFS_FIELD_W];
    end

    // one process, so each next vector has a single driver
    always_comb begin
        pinOutNext = '0;
        pinOeNext = '0;
        portInNext = '0;
        timerInNext = '0;
        for (int i = 0; i < NUM_PINS; i++) begin
            // codes 000 and 001 only; others are prohibited
            case (pinMode[i])
                PFS_MODE_PORT: begin
                    pinOutNext[i] = portOut[i];
                    pinOeNext[i] = portOe[i];
                    portInNext[i] = syncB[i];
                end
                PFS_MODE_TIMER: begin
                    pinOutNext[i] = timerOut[i];
                    pinOeNext[i] = timerOe[i];
                    timerInNext[i] = syncB[i];
                end
                default: begin
                    // prohibited code: pin floats, nobody sees it
                    pinOeNext[i] = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            syncA <= '0;
            syncB <= '0;
            pinOutReg <= '0;
            pinOeReg <= '0;
            portInReg <= '0;
            timerInReg <= '0;
        end else begin
            // pin levels are asynchronous to clock
            syncA <= pinIn;
            syncB <= syncA;
            pinOutReg <= pinOutNext;
            pinOeReg <= pinOeNext;
            portInReg <= portInNext;
            timerInReg <= timerInNext;
        end
    end

    assign pinOut = pinOutReg;
    assign pinOe = pinOeReg;
    assign portIn = portInReg;
    assign timerIn = timerInReg;

    // ==========================================================
    // assertions
    AST_PIN10_ROUTE: assert property (
        @(posedge clock) disable iff (rst)
        pinMode[2] == `PFS_CODE_TIMER |=>
            pinOe[2] == $past(timerOe[2]) &&
            pinOut[2] == $past(timerOut[2]))
        else $error("pin 10 not routed to timer C");

    AST_RSV_ZERO: assert property (
        @(posedge clock) disable iff (rst)
        (regWrEn && hitFunc) ##1 (regRdEn && hitFunc) |=>
            regRdData == ($past(regWrData, 2) & ~`PFS_RSV_MASK))
        else $error("read back wrong or reserved bit set");

    AST_PIN9_ROUTE: assert property (
        @(posedge clock) disable iff (rst)
        pinMode[1] == `PFS_CODE_PORT |=>
            pinOe[1] == $past(portOe[1]) &&
            pinOut[1] == $past(portOut[1]))
        else $error("pin 9 not routed to port");

    AST_PIN8_FIELD: assert property (
        @(posedge clock) disable iff (rst)
        regWrEn && hitFunc |=>
            pinMode[0] == $past(regWrData[`PFS_FIELD_W-1:0]))
        else $error("pin 8 field not written at bits 2:0");

    AST_PIN8_ROUTE: assert property (
        @(posedge clock) disable iff (rst)
        pinMode[0] == `PFS_CODE_TIMER |=>
            pinOe[0] == $past(timerOe[0]) &&
            pinOut[0] == $past(timerOut[0]))
        else $error("pin 8 not routed to timer A");

    AST_RESET_PORT: assert property (
        @(posedge clock) disable iff (rst)
        $past(rst) |-> pinMode[1] == `PFS_CODE_PORT &&
            pinMode[2] == `PFS_CODE_PORT && regRdData == '0)
        else $error("pin 9 or 10 not port after reset");

    AST_PIN11_ROUTE: assert property (
        @(posedge clock) disable iff (rst)
        pinMode[3] == `PFS_CODE_TIMER |=>
            pinOe[3] == $past(timerOe[3]) && portIn[3] == 1'b0)
        else $error("pin 11 not routed to timer D");

    AST_IN_STEER: assert property (
        @(posedge clock) disable iff (rst)
        !$past(rst) && !$past(rst, 2) && !$past(rst, 3) &&
        $past(pinMode[0] == `PFS_CODE_PORT) |->
            portIn[0] == $past(pinIn[0], 3) && timerIn[0] == 1'b0)
        else $error("pin 8 input not steered to port");

    AST_TIMER_IN: assert property (
        @(posedge clock) disable iff (rst)
        !$past(rst) && !$past(rst, 2) && !$past(rst, 3) &&
        $past(pinMode[1] == `PFS_CODE_TIMER) |->
            timerIn[1] == $past(pinIn[1], 3) && portIn[1] == 1'b0)
        else $error("pin 9 input not steered to timer B");

    // ==========================================================
    // routing of the other mode on each pin, plus the pin 11 timer output
    AST_PIN8_PORT: assert property (
        @(posedge clock) disable iff (rst)
        pinMode[0] == `PFS_CODE_PORT |=>
            pinOe[0] == $past(portOe[0]) &&
            pinOut[0] == $past(portOut[0]))
        else $error("pin 8 not routed to port");

    AST_PIN9_TIMER: assert property (
        @(posedge clock) disable iff (rst)
        pinMode[1] == `PFS_CODE_TIMER |=>
            pinOe[1] == $past(timerOe[1]) &&
            pinOut[1] == $past(timerOut[1]))
        else $error("pin 9 not routed to timer B");

    AST_PIN10_PORT: assert property (
        @(posedge clock) disable iff (rst)
        pinMode[2] == `PFS_CODE_PORT |=>
            pinOe[2] == $past(portOe[2]) &&
            pinOut[2] == $past(portOut[2]))
        else $error("pin 10 not routed to port");

    AST_PIN11_PORT: assert property (
        @(posedge clock) disable iff (rst)
        pinMode[3] == `PFS_CODE_PORT |=>
            pinOe[3] == $past(portOe[3]) &&
            pinOut[3] == $past(portOut[3]))
        else $error("pin 11 not routed to port");

    AST_PIN11_OUT: assert property (
        @(posedge clock) disable iff (rst)
        pinMode[3] == `PFS_CODE_TIMER |=>
            pinOut[3] == $past(timerOut[3]))
        else $error("pin 11 output not taken from timer D");

    // prohibited codes float the pin; a choice, the rules leave it open
    for (genvar k = 0; k < NUM_PINS; k++) begin : g_float
        AST_FLOAT: assert property (
            @(posedge clock) disable iff (rst)
            pinMode[k] != `PFS_CODE_PORT &&
            pinMode[k] != `PFS_CODE_TIMER |=>
                !pinOe[k] && !pinOut[k] && !portIn[k] && !timerIn[k])
            else $error("prohibited code does not float the pin");
    end

    // ==========================================================
    // register bus assertions
    AST_RSV_READ: assert property (
        @(posedge clock) disable iff (rst)
        (regRdData & `PFS_RSV_MASK) == '0)
        else $error("reserved bit read as one");

    AST_RSV_STORE: assert property (
        @(posedge clock) disable iff (rst)
        (funcReg & `PFS_RSV_MASK) == '0)
        else $error("reserved bit stored");

    AST_RD_IDLE: assert property (
        @(posedge clock) disable iff (rst)
        !(regRdEn && hitFunc) |=> regRdData == '0)
        else $error("read data shown outside its slot");

    AST_RD_DATA: assert property (
        @(posedge clock) disable iff (rst)
        regRdEn && hitFunc |=>
            regRdData == ($past(funcReg) & ~`PFS_RSV_MASK))
        else $error("read data differs from stored fields");

    AST_UNMAPPED_WR: assert property (
        @(posedge clock) disable iff (rst)
        regWrEn && !hitFunc |=> $stable(funcReg))
        else $error("write to other address changed fields");

    AST_FUNC_HOLD: assert property (
        @(posedge clock) disable iff (rst)
        !regWrEn |=> $stable(funcReg))
        else $error("fields changed without a write");

    AST_PIN9_FIELD: assert property (
        @(posedge clock) disable iff (rst)
        regWrEn && hitFunc |=> pinMode[1] ==
            $past(regWrData[`PFS_FIELD_STRIDE +: `PFS_FIELD_W]))
        else $error("pin 9 field not written");

    AST_PIN10_FIELD: assert property (
        @(posedge clock) disable iff (rst)
        regWrEn && hitFunc |=> pinMode[2] ==
            $past(regWrData[2*`PFS_FIELD_STRIDE +: `PFS_FIELD_W]))
        else $error("pin 10 field not written");

    AST_PIN11_FIELD: assert property (
        @(posedge clock) disable iff (rst)
        regWrEn && hitFunc |=> pinMode[3] ==
            $past(regWrData[3*`PFS_FIELD_STRIDE +: `PFS_FIELD_W]))
        else $error("pin 11 field not written");
endmodule

/* File: include/pfs_defines.svh */
// constants for the port E upper pin function select block
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH

// ==========================================================
// register access
`define PFS_ADDR_W 8
`define PFS_DATA_W 16
`define PFS_OFS_FUNC 8'h00
`define PFS_RST_VAL 16'h0000
`define PFS_READ_IDLE 16'h0000

// ==========================================================
// field layout: pin n field at bit (n-8)*stride
`define PFS_NUM_PINS 4
`define PFS_FIELD_W 3
`define PFS_FIELD_STRIDE 4
`define PFS_RSV_MASK 16'h8888

// ==========================================================
// mode codes
`define PFS_CODE_PORT 3'h0
`define PFS_CODE_TIMER 3'h1

`endif

/* File: include/pfs_pkg.sv */
// types for the port E upper pin function select block
`include "pfs_defines.svh"

package pfs_pkg;
    typedef enum logic [`PFS_FIELD_W-1:0] {
        PFS_MODE_PORT = `PFS_CODE_PORT,
        PFS_MODE_TIMER = `PFS_CODE_TIMER
    } pfs_mode_t;

    typedef logic [`PFS_ADDR_W-1:0] pfs_addr_t;
    typedef logic [`PFS_DATA_W-1:0] pfs_data_t;
    typedef logic [`PFS_FIELD_W-1:0] pfs_field_t;
endpackage

/* File: bench/pfs_pin_mux_tb_top.sv */
// self-checking bench for the port E upper pin function select block
module pfs_pin_mux_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pfs_pkg::*;
    // ==========================================================
    // stimulus and wiring
    logic clock = 0;
    logic rst = 1;
    pfs_addr_t regAddr = 8'h00;
    pfs_data_t regWrData = 16'h0000;
    logic regWrEn = 0;
    logic regRdEn = 0;
    pfs_data_t regRdData;
    logic [3:0] pinIn = 4'h0;
    logic [3:0] pinOut, pinOe, portIn, timerIn;
    logic [3:0] portOut = 4'hA;
    logic [3:0] portOe = 4'hC;
    logic [3:0] timerOut = 4'h5;
    logic [3:0] timerOe = 4'h3;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    pfs_pin_mux DUT (.clock(clock), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .portOut(portOut), .portOe(portOe),
        .portIn(portIn), .timerOut(timerOut), .timerOe(timerOe),
        .timerIn(timerIn));
    always #4 clock = ~clock;
    // cuts a hang short; all tests need well under 300 cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            give_verdict();
        end
    end
    // ==========================================================
    // shared tasks
    task automatic check(input pfs_data_t seen, input pfs_data_t exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bus tasks start just after a rising edge and end on one
    task automatic reg_write(input pfs_addr_t a, input pfs_data_t d);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1;
        @(posedge clock);
        regWrEn <= 0;
    endtask
    task automatic reg_read(input pfs_addr_t a, output pfs_data_t d);
        regAddr <= a;
        regRdEn <= 1;
        @(posedge clock);
        regRdEn <= 0;
        // data stand only in the cycle after the strobe
        #1 d = regRdData;
        @(posedge clock);
    endtask
    task automatic give_verdict();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic test_reset();
        pfs_data_t d;
        // reset leaves every pin on the port side
        check(16'(pinOe), 16'(portOe));
        check(16'(pinOut), 16'(portOut));
        @(posedge clock);
        reg_read(8'h00, d);
        check(d, 16'h0000);
    endtask
    task automatic test_reserved();
        pfs_data_t d;
        // all ones lands reserved bits too; they must read back clear
        reg_write(8'h00, 16'hFFFF);
        reg_read(8'h00, d);
        check(d, 16'h7777);
        reg_write(8'h04, 16'h0000);
        reg_read(8'h00, d);
        check(d, 16'h7777);
        reg_read(8'h04, d);
        check(d, 16'h0000);
        reg_write(8'h00, 16'h0000);
    endtask
    // t / p: pins expected on timer / port; neither means floated
    task automatic route(input pfs_data_t mode, input logic [3:0] t,
            input logic [3:0] p);
        pfs_data_t d;
        logic [3:0] eo;
        logic [3:0] ee;
        eo = (timerOut & t) | (portOut & p);
        ee = (timerOe & t) | (portOe & p);
        reg_write(8'h00, mode);
        reg_read(8'h00, d);
        check(d, mode);
        pinIn <= 4'h6;
        repeat (4) @(posedge clock);
        #1;
        check(16'(pinOut), 16'(eo));
        check(16'(pinOe), 16'(ee));
        check(16'(timerIn), 16'(4'h6 & t));
        check(16'(portIn), 16'(4'h6 & p));
        @(posedge clock);
        pinIn <= 4'h9;
        repeat (4) @(posedge clock);
        #1;
        check(16'(timerIn), 16'(4'h9 & t));
        check(16'(portIn), 16'(4'h9 & p));
        @(posedge clock);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge clock);
        rst <= 0;
        @(posedge clock);
        #1;
        test_reset();
        test_reserved();
        route(16'h1111, 4'hF, 4'h0);
        route(16'h0000, 4'h0, 4'hF);
        route(16'h0101, 4'h5, 4'hA);
        route(16'h1010, 4'hA, 4'h5);
        route(16'h2222, 4'h0, 4'h0);
        give_verdict();
    end
endmodule
